//--- logic/timer_counter.sv
// ==========================================================================
// Sixteen-bit timer/counter with prescaler, buffered 16-bit access,
// compare-trigger reset and secondary-oscillator power mode tracking.
// Assumes an AHB-Lite master on hclk; ext_clk_pin is asynchronous.
// ==========================================================================
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps

module timer_counter (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        ext_clk_pin,
	input  wire logic        cmp1_event,
	input  wire logic        cmp2_event,
	input  wire logic        sleep_exec,
	input  wire logic        wake_event,
	output logic             overflow_irq,
	output logic             osc_run,
	output logic             osc_low_power,
	output logic             secondary_clock_active,
	output logic             sec_idle_active,
	output logic             sleep_active
);
	import timer_pkg::*;

	// ======================================================================
	// State of the whole block
	typedef struct packed {
		// Bus data-phase tracking and registered read data
		logic        ph_active;
		logic        ph_ready;
		logic        ph_write;
		logic        ph_mapped;
		logic [7:0]  ph_addr;
		logic [31:0] rdata;
		// Control, counter, prescaler and instruction-cycle phase
		logic [7:0]  ctrl;
		logic [15:0] count;
		logic [7:0]  high_buf;
		logic [2:0]  presc;
		logic [1:0]  cyc;
		logic        sync1;
		logic        sync2;
		logic        sync3;
		logic        armed;
		logic        ext_pend;
		logic        flag;
		logic        irq_en;
		logic [1:0]  system_clock_select;
		logic        idle_on_sleep;
		logic        lp_cfg;
		logic [9:0]  cmp_cfg;
		power_t      pwr;
	} state_t;

	state_t state_reg;
	state_t state_next;

	// ======================================================================
	// Mask of prescaler bits that must be all ones to pass a tick
	function automatic logic [2:0] presc_mask(input logic [1:0] sel);
		logic [2:0] m;
		m = 3'h0;
		unique case (sel)
			2'b00: m = 3'h0;
			2'b01: m = 3'h1;
			2'b10: m = 3'h3;
			2'b11: m = 3'h7;
		endcase
		return m;
	endfunction

	// Compare unit asks for a timer reset
	function automatic logic cmp_fires(input logic ev, input logic use_t,
			input logic [3:0] mode);
		return ev & use_t & (mode == TRIGGER_MODE);
	endfunction

	// ======================================================================
	// Combinational next state
	always_comb begin
		logic        tick_src;
		logic        ext_rise;
		logic        instr_tick;
		logic        async_mode;
		logic        count_live;
		logic        presc_pass;
		logic        trig1;
		logic        trig2;
		logic        wr_count;
		logic        do_access;
		logic [7:0]  wbyte;
		logic        set_flag;
		logic        clr_flag;
		logic [31:0] rd;

		state_next = state_reg;
		wbyte      = hwdata[7:0];
		rd         = 32'h0000_0000;
		wr_count   = 1'b0;
		set_flag   = 1'b0;
		clr_flag   = 1'b0;
		tick_src   = 1'b0;
		ext_rise   = 1'b0;
		instr_tick = 1'b0;
		async_mode = 1'b0;
		count_live = 1'b0;
		presc_pass = 1'b0;
		trig1      = 1'b0;
		trig2      = 1'b0;
		do_access  = 1'b0;

		// Pin synchroniser; first stage feeds only the second
		state_next.sync1 = ext_clk_pin;
		state_next.sync2 = state_reg.sync1;
		state_next.sync3 = state_reg.sync2;

		// Instruction-cycle phase, oscillator divided by four
		state_next.cyc = state_reg.cyc + 2'h1;
		instr_tick     = (state_reg.cyc == CYC_LAST);

		// A falling level arms the counter before the next rising edge
		if (!state_reg.sync2) begin
			state_next.armed = 1'b1;
		end
		ext_rise = state_reg.sync2 & ~state_reg.sync3 & state_reg.armed;

		async_mode = state_reg.ctrl[BIT_SRC_SEL] & state_reg.ctrl[BIT_BYPASS];

		// Source edge selection; switching bypass may drop or add one edge
		if (!state_reg.ctrl[BIT_SRC_SEL]) begin
			tick_src = instr_tick;
			state_next.ext_pend = 1'b0;
		end else if (state_reg.ctrl[BIT_BYPASS]) begin
			tick_src = ext_rise;
			state_next.ext_pend = 1'b0;
		end else begin
			// Synchronised counter waits for the instruction-cycle boundary
			tick_src = state_reg.ext_pend & instr_tick;
			if (ext_rise) begin
				state_next.ext_pend = 1'b1;
			end else if (instr_tick) begin
				state_next.ext_pend = 1'b0;
			end
		end

		// Sleep stops the instruction clock but not the asynchronous counter
		count_live = state_reg.ctrl[BIT_TIMER_ON] &
			(async_mode | (state_reg.pwr != PWR_SLEEP));

		// Prescaler and counter advance
		presc_pass = 1'b0;
		if (count_live && tick_src) begin
			presc_pass = ((state_reg.presc & presc_mask(state_reg.ctrl[BIT_PS_HI:BIT_PS_LO]))
				== presc_mask(state_reg.ctrl[BIT_PS_HI:BIT_PS_LO]));
			state_next.presc = state_reg.presc + 3'h1;
		end
		if (presc_pass) begin
			state_next.count = state_reg.count + 16'h0001;
			if (state_reg.count == COUNT_MAX) begin
				set_flag = 1'b1;
			end
		end

		// Compare triggers reset the count, never in asynchronous mode
		trig1 = cmp_fires(cmp1_event, state_reg.cmp_cfg[BIT_CMP1_USE],
			state_reg.cmp_cfg[3:0]);
		trig2 = cmp_fires(cmp2_event, state_reg.cmp_cfg[BIT_CMP2_USE],
			state_reg.cmp_cfg[7:4]);
		if ((trig1 || trig2) && !async_mode) begin
			state_next.count = RST_COUNT;
			set_flag = 1'b0;
		end

		// ------------------------------------------------------------------
		// Bus data phase: first cycle does the access, second completes it
		do_access = state_reg.ph_active & ~state_reg.ph_ready;
		if (do_access) begin
			state_next.ph_ready = 1'b1;
			if (state_reg.ph_write && state_reg.ph_mapped) begin
				unique case (state_reg.ph_addr)
					OFS_CONTROL: begin
						state_next.ctrl = wbyte & ~(8'h01 << BIT_SEC_ACTIVE);
						if (wbyte[BIT_TIMER_ON] && !state_reg.ctrl[BIT_TIMER_ON]) begin
							state_next.armed = 1'b0;
						end
					end
					OFS_COUNT_LOW: begin
						wr_count = 1'b1;
						state_next.presc = 3'h0;
						if (state_reg.ctrl[BIT_WIDE]) begin
							state_next.count = {state_reg.high_buf, wbyte};
						end else begin
							state_next.count = {state_reg.count[15:8], wbyte};
						end
					end
					OFS_COUNT_HIGH: begin
						if (state_reg.ctrl[BIT_WIDE]) begin
							state_next.high_buf = wbyte;
						end else begin
							wr_count = 1'b1;
							state_next.presc = 3'h0;
							// Live low byte kept, so a coincident trigger is ignored
							state_next.count = {wbyte, state_reg.count[7:0]};
						end
					end
					OFS_FLAG: begin
						// Writing zero clears; writing one leaves the flag alone
						clr_flag = ~wbyte[0];
					end
					OFS_ENABLE: begin
						state_next.irq_en = wbyte[0];
					end
					OFS_OSC_CTRL: begin
						state_next.system_clock_select           = wbyte[1:0];
						state_next.idle_on_sleep = wbyte[BIT_IDLE_ON_SLEEP];
					end
					OFS_CONFIG: begin
						state_next.lp_cfg = wbyte[0];
					end
					OFS_COMPARE: begin
						state_next.cmp_cfg = hwdata[9:0];
					end
					default: begin
					end
				endcase
				// A counter write also re-arms the falling-edge check
				if (wr_count) begin
					state_next.armed = 1'b0;
				end
			end else if (state_reg.ph_mapped) begin
				unique case (state_reg.ph_addr)
					OFS_CONTROL: begin
						rd[7:0] = state_reg.ctrl;
						rd[BIT_SEC_ACTIVE] = (state_reg.pwr == PWR_SEC_RUN) ||
							(state_reg.pwr == PWR_SEC_IDLE);
					end
					OFS_COUNT_LOW: begin
						rd[7:0] = state_reg.count[7:0];
						if (state_reg.ctrl[BIT_WIDE]) begin
							state_next.high_buf = state_reg.count[15:8];
						end
					end
					OFS_COUNT_HIGH: begin
						rd[7:0] = state_reg.ctrl[BIT_WIDE] ? state_reg.high_buf
							: state_reg.count[15:8];
					end
					OFS_FLAG: begin
						rd[0] = state_reg.flag;
					end
					OFS_ENABLE: begin
						rd[0] = state_reg.irq_en;
					end
					OFS_OSC_CTRL: begin
						rd[1:0] = state_reg.system_clock_select;
						rd[BIT_IDLE_ON_SLEEP] = state_reg.idle_on_sleep;
					end
					OFS_CONFIG: begin
						rd[0] = state_reg.lp_cfg;
					end
					OFS_COMPARE: begin
						rd[9:0] = state_reg.cmp_cfg;
					end
					default: begin
					end
				endcase
			end
			// Read data holds across writes until the next read
			if (!state_reg.ph_write) begin
				state_next.rdata = rd;
			end
		end

		// Written value beats the trigger reset in the same cycle
		if (wr_count) begin
			set_flag = 1'b0;
		end

		// Overflow flag: hardware set wins over software clear
		if (set_flag) begin
			state_next.flag = 1'b1;
		end else if (clr_flag) begin
			state_next.flag = 1'b0;
		end

		// Address phase accepted when the bus is ready
		if (hready) begin
			if (hsel && htrans[1]) begin
				state_next.ph_active = 1'b1;
				state_next.ph_ready  = 1'b0;
				state_next.ph_write  = hwrite;
				// Unmapped words still complete with OKAY and read as zero
				state_next.ph_mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
				state_next.ph_addr   = haddr[7:0];
			end else if (state_reg.ph_ready) begin
				state_next.ph_active = 1'b0;
				state_next.ph_ready  = 1'b0;
			end
		end

		// ------------------------------------------------------------------
		// Power-mode tracking for the secondary oscillator
		unique case (state_reg.pwr)
			PWR_RUN: begin
				if (sleep_exec) begin
					state_next.pwr = PWR_SLEEP;
				end else if (state_reg.system_clock_select == SCS_SECONDARY) begin
					state_next.pwr = PWR_SEC_RUN;
				end
			end
			PWR_SEC_RUN: begin
				if (sleep_exec && !state_reg.idle_on_sleep) begin
					state_next.pwr = PWR_SEC_IDLE;
				end else if (sleep_exec) begin
					state_next.pwr = PWR_SLEEP;
				end else if (state_reg.system_clock_select != SCS_SECONDARY) begin
					state_next.pwr = PWR_RUN;
				end
			end
			PWR_SEC_IDLE: begin
				// Any wake source returns to secondary run
				if (wake_event || (state_reg.flag && state_reg.irq_en)) begin
					state_next.pwr = PWR_SEC_RUN;
				end
			end
			PWR_SLEEP: begin
				// Overflow interrupt wakes the processor from sleep
				if (wake_event || (state_reg.flag && state_reg.irq_en)) begin
					state_next.pwr = (state_reg.system_clock_select == SCS_SECONDARY) ? PWR_SEC_RUN
						: PWR_RUN;
				end
			end
		endcase
	end

	// ======================================================================
	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Clear everything, then load the named reset values
			state_reg               <= '0;
			state_reg.ctrl          <= RST_CONTROL;
			state_reg.count         <= RST_COUNT;
			state_reg.system_clock_select           <= RST_SCS;
			state_reg.cmp_cfg       <= RST_COMPARE;
			state_reg.pwr           <= PWR_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// ======================================================================
	// Outputs
	assign hrdata        = state_reg.rdata;
	// Ready low only in the first data-phase cycle
	assign hreadyout     = ~state_reg.ph_active | state_reg.ph_ready;
	assign hresp         = 1'b0;
	// Oscillator runs on its enable alone, whatever the power mode
	assign osc_run       = state_reg.ctrl[BIT_OSC_EN];
	assign osc_low_power = state_reg.lp_cfg;
	assign overflow_irq  = state_reg.flag & state_reg.irq_en;
	assign secondary_clock_active = (state_reg.pwr == PWR_SEC_RUN) ||
		(state_reg.pwr == PWR_SEC_IDLE);
	assign sec_idle_active = (state_reg.pwr == PWR_SEC_IDLE);
	assign sleep_active    = (state_reg.pwr == PWR_SLEEP);

endmodule

//--- shared/timer_pkg.sv
// ==========================================================================
// Constants and types for the sixteen-bit timer/counter.
// Assumes one clock (hclk, also the oscillator clock) and an AHB-Lite host.
// ==========================================================================
// Summary of operation
// - Prescaler divides count clock by 1/2/4/8.
// - Select 11/10/01 gives divide 8/4/2.
// - Source select 0 internal, 1 external.
// - Hidden prescaler cleared by every write that loads the counter.
// - Bypass counts external edges without phase alignment.
// - Asynchronous counting continues and wakes from sleep.
// - Mode switch may skip or add one.
// - Wide mode maps high address to buffer.
// - Wide low read copies high into buffer.
// - Wide high write buffers; low write loads both.
// - Wide mode clears prescaler on low writes only.
// - Oscillator runs while enabled, every power mode.
// - Clock select 01 enters secondary run.
// - Secondary run plus sleep enters secondary idle when the idle bit (7) is clear, else sleep.
// - Status bit set while oscillator clocks system.
// - Low-power bit selects oscillator power level.
// - Count 0000h to FFFFh, wrap sets flag.
// - Interrupt raised only when enable bit set.
// - Compare mode 1011 trigger resets counter.
// - Trigger ignored in asynchronous counter mode.
// - Counter write wins over coincident trigger.
// - Second compare trigger never sets flag.
package timer_pkg;

	// ======================================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_COUNT_LOW  = 8'h04;
	localparam logic [7:0] OFS_COUNT_HIGH = 8'h08;
	localparam logic [7:0] OFS_FLAG       = 8'h0c;
	localparam logic [7:0] OFS_ENABLE     = 8'h10;
	localparam logic [7:0] OFS_OSC_CTRL   = 8'h14;
	localparam logic [7:0] OFS_CONFIG     = 8'h18;
	localparam logic [7:0] OFS_COMPARE    = 8'h1c;

	// ======================================================================
	// Control register field positions
	localparam int BIT_WIDE       = 7;
	localparam int BIT_SEC_ACTIVE = 6;
	localparam int BIT_PS_HI      = 5;
	localparam int BIT_PS_LO      = 4;
	localparam int BIT_OSC_EN     = 3;
	localparam int BIT_BYPASS     = 2;
	localparam int BIT_SRC_SEL    = 1;
	localparam int BIT_TIMER_ON   = 0;
	// Oscillator control fields
	localparam int BIT_IDLE_ON_SLEEP = 7;
	// Compare configuration fields: modes in [3:0],[7:4]; use-this-timer in 8,9
	localparam int BIT_CMP1_USE = 8;
	localparam int BIT_CMP2_USE = 9;

	// ======================================================================
	// Reset values and fixed codes
	localparam logic [7:0]  RST_CONTROL = 8'h00;
	localparam logic [15:0] RST_COUNT   = 16'h0000;
	localparam logic [1:0]  RST_SCS     = 2'h0;
	localparam logic [9:0]  RST_COMPARE = 10'h000;
	localparam logic [1:0]  SCS_SECONDARY = 2'h1;
	localparam logic [3:0]  TRIGGER_MODE  = 4'hb;
	localparam logic [15:0] COUNT_MAX     = 16'hffff;
	// Oscillator clocks per instruction cycle, minus one
	localparam logic [1:0]  CYC_LAST = 2'h3;

	typedef enum logic [1:0] {
		PWR_RUN      = 2'b00,
		PWR_SEC_RUN  = 2'b01,
		PWR_SEC_IDLE = 2'b10,
		PWR_SLEEP    = 2'b11
	} power_t;

endpackage

//--- dv/timer_counter_assertions.sv
// Concurrent checks on the timer/counter top-level ports.
// Assumes hready is fed from hreadyout and a single hclk domain.
`timescale 1ns/10ps

module timer_counter_assertions (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        sleep_exec,
	input wire logic        wake_event,
	input wire logic        overflow_irq,
	input wire logic        osc_run,
	input wire logic        osc_low_power,
	input wire logic        secondary_clock_active,
	input wire logic        sec_idle_active,
	input wire logic        sleep_active
);
	import timer_pkg::*;

	logic tk, hit, wctl, wcfg, wosc, rdp, idle_q;

	// ======================================================================
	// Bus decode: flags are high during the first data-phase cycle
	assign tk  = hsel && htrans[1] && hready;
	assign hit = tk && hwrite && haddr[31:8] == 24'h0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wctl, wcfg, wosc, rdp, idle_q} <= '0;
		end else begin
			wctl <= hit && haddr[7:0] == OFS_CONTROL;
			wcfg <= hit && haddr[7:0] == OFS_CONFIG;
			wosc <= hit && haddr[7:0] == OFS_OSC_CTRL;
			rdp  <= tk && !hwrite;
			if (wosc) begin
				idle_q <= hwdata[BIT_IDLE_ON_SLEEP];
			end
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ======================================================================
	// Properties
	chk_wait_state: assert property (tk |=> !hreadyout ##1 hreadyout)
		else $error("wait state pattern wrong");
	chk_okay_resp: assert property (hresp == 1'b0)
		else $error("response not okay");
	chk_rdata_hold: assert property ($changed(hrdata) |-> $past(rdp))
		else $error("read data moved without a read");
	chk_osc_follow: assert property ($changed(osc_run) |-> $past(wctl))
		else $error("oscillator run changed without control write");
	chk_lp_follow: assert property ($changed(osc_low_power) |-> $past(wcfg))
		else $error("low power level changed without config write");
	chk_idle_inside: assert property (sec_idle_active |-> secondary_clock_active)
		else $error("idle without secondary clock status");
	chk_sleep_apart: assert property (sleep_active |-> !secondary_clock_active)
		else $error("secondary clock status during sleep");
	chk_sec_entry: assert property (wosc && hwdata[1:0] == SCS_SECONDARY
		|-> ##[1:3] secondary_clock_active)
		else $error("secondary run not entered");
	chk_idle_entry: assert property (secondary_clock_active && !sec_idle_active
		&& sleep_exec && !idle_q && !overflow_irq && !wake_event |-> ##[1:2] sec_idle_active)
		else $error("secondary idle not entered");
	chk_irq_wake: assert property (sleep_active && overflow_irq |-> ##[1:3] !sleep_active)
		else $error("overflow did not wake");

	cover property ($rose(sec_idle_active));
	cover property ($rose(overflow_irq));
	cover property ($fell(sleep_active));
endmodule

bind timer_counter timer_counter_assertions timer_counter_assertions_i (.*);

//--- dv/ext_source_model.sv
// Far side: external count clock pin and compare-unit event pulses.
// Assumes its tasks are called just after a rising hclk edge.
`timescale 1ns/10ps

module ext_source_model (
	input  wire logic hclk,
	output logic      ext_clk_pin,
	output logic      cmp1_event,
	output logic      cmp2_event
);
	// Pin rests low so the first rising edge follows a low level
	initial begin
		ext_clk_pin = 1'b0;
		cmp1_event  = 1'b0;
		cmp2_event  = 1'b0;
	end

	// Rising edges, eight hclk low then eight high, back to low
	task automatic pulses(input int n);
		repeat (n) begin
			repeat (8) @(posedge hclk);
			ext_clk_pin <= 1'b1;
			repeat (8) @(posedge hclk);
			ext_clk_pin <= 1'b0;
		end
	endtask

	// One-cycle trigger from compare unit 1 or 2
	task automatic fire(input int unit);
		if (unit == 1) begin
			cmp1_event <= 1'b1;
		end else begin
			cmp2_event <= 1'b1;
		end
		@(posedge hclk);
		cmp1_event <= 1'b0;
		cmp2_event <= 1'b0;
	endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench: AHB-Lite register tasks and scenario sequence.
// Assumes the far-side model drives the pin and compare events.
`timescale 1ns/10ps

module tb_top;
	import timer_pkg::*;

	logic        hclk, hresetn, hsel, hwrite, sleep_exec, wake_event;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, ext_clk_pin, cmp1_event, cmp2_event;
	logic        overflow_irq, osc_run, osc_low_power, secondary_clock_active;
	logic        sec_idle_active, sleep_active;
	int          failures, cmp_count;

	timer_counter timer_counter_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_clk_pin,
		.cmp1_event, .cmp2_event, .sleep_exec, .wake_event, .overflow_irq, .osc_run,
		.osc_low_power, .secondary_clock_active, .sec_idle_active, .sleep_active);
	ext_source_model src_i (.hclk, .ext_clk_pin, .cmp1_event, .cmp2_event);

	// 10 MHz clock
	initial hclk = 1'b0;
	always #50 hclk = ~hclk;

	// ======================================================================
	// Tasks
	task automatic ck(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic tally_and_finish();
		if (failures == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// One transfer: hold each phase until hready is seen high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic rdy;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		for (int p = 0; p < 2; p++) begin
			n = 0;
			do begin
				@(negedge hclk);
				rdy = hreadyout;
				r = hrdata;
				@(posedge hclk);
				n++;
			end while (rdy !== 1'b1 && n < 40);
			if (rdy !== 1'b1) begin
				failures++;
				tally_and_finish();
			end
			if (p == 0) begin
				htrans <= 2'b00;
				hsel <= 1'b0;
				hwdata <= d;
			end
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		ck(nm, r, e);
	endtask

	// Wait, bounded, for a one-bit output to settle at its expected level
	task automatic st(input string nm, ref logic s, input logic e);
		@(negedge hclk);
		repeat (80) if (s !== e) @(negedge hclk);
		ck(nm, {31'h0, s}, {31'h0, e});
		@(posedge hclk);
	endtask

	// One-cycle pulse on sleep_exec (0) or wake_event (1)
	task automatic pulse(input bit wake);
		if (wake) begin
			wake_event <= 1'b1;
		end else begin
			sleep_exec <= 1'b1;
		end
		@(posedge hclk);
		sleep_exec <= 1'b0;
		wake_event <= 1'b0;
	endtask

	// ======================================================================
	// Scenario sequence
	initial begin
		{hresetn, hsel, hwrite, sleep_exec, wake_event, haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		failures = 0;
		cmp_count = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rc("ctl", OFS_CONTROL, 32'h0);
		rc("low", OFS_COUNT_LOW, 32'h0);
		rc("cmp", OFS_COMPARE, 32'h0);
		wr(8'h40, 32'hff);
		rc("unmapped", 8'h40, 32'h0);
		// Each ratio gives about eight counts in its window
		for (int ps = 0; ps < 4; ps++) begin
			wr(OFS_COUNT_LOW, 32'h0);
			wr(OFS_COUNT_HIGH, 32'h0);
			wr(OFS_CONTROL, 32'h1 | (ps << 4));
			repeat (32 << ps) @(posedge hclk);
			wr(OFS_CONTROL, 32'h0);
			bus(1'b0, OFS_COUNT_LOW, 32'h0);
			ck("ratio", {31'h0, r >= 32'd7 && r <= 32'd9}, 32'h1);
		end
		// Wrap with interrupt enabled, then disabled
		for (int en = 1; en >= 0; en--) begin
			wr(OFS_ENABLE, en);
			wr(OFS_COUNT_LOW, 32'hfe);
			wr(OFS_COUNT_HIGH, 32'hff);
			wr(OFS_CONTROL, 32'h1);
			repeat (40) @(posedge hclk);
			st("irq", overflow_irq, en[0]);
			wr(OFS_CONTROL, 32'h0);
			rc("flag", OFS_FLAG, 32'h1);
			rc("high", OFS_COUNT_HIGH, 32'h0);
			wr(OFS_FLAG, 32'h0);
			st("irq", overflow_irq, 1'b0);
		end
		// Wide access: buffered high byte
		wr(OFS_COUNT_LOW, 32'h34);
		wr(OFS_COUNT_HIGH, 32'h56);
		wr(OFS_CONTROL, 32'h80);
		wr(OFS_COUNT_HIGH, 32'hab);
		rc("buf", OFS_COUNT_HIGH, 32'hab);
		wr(OFS_CONTROL, 32'h0);
		rc("live", OFS_COUNT_HIGH, 32'h56);
		wr(OFS_CONTROL, 32'h80);
		wr(OFS_COUNT_LOW, 32'hcd);
		wr(OFS_COUNT_HIGH, 32'h11);
		rc("low", OFS_COUNT_LOW, 32'hcd);
		rc("copy", OFS_COUNT_HIGH, 32'hab);
		wr(OFS_CONTROL, 32'h0);
		rc("both", OFS_COUNT_HIGH, 32'hab);
		// Compare triggers while running at divide by 8
		wr(OFS_COMPARE, 32'h2b0);
		wr(OFS_CONTROL, 32'h31);
		src_i.fire(2);
		rc("trig2", OFS_COUNT_HIGH, 32'h0);
		rc("noflag", OFS_FLAG, 32'h0);
		wr(OFS_COUNT_HIGH, 32'h12);
		src_i.fire(1);
		rc("nomode", OFS_COUNT_HIGH, 32'h12);
		wr(OFS_COMPARE, 32'h10b);
		src_i.fire(1);
		rc("trig1", OFS_COUNT_HIGH, 32'h0);
		// Counter write in the same cycle as a trigger keeps the written value
		fork
			wr(OFS_COUNT_HIGH, 32'h12);
			begin
				@(posedge hclk);
				src_i.fire(1);
			end
		join
		rc("wr_wins", OFS_COUNT_HIGH, 32'h12);
		// Oscillator and power modes
		wr(OFS_CONFIG, 32'h1);
		st("lp", osc_low_power, 1'b1);
		wr(OFS_CONFIG, 32'h0);
		st("lp", osc_low_power, 1'b0);
		wr(OFS_CONTROL, 32'h08);
		st("osc", osc_run, 1'b1);
		repeat (20) @(posedge hclk); // Start-up delay
		wr(OFS_OSC_CTRL, 32'h1);
		st("sec", secondary_clock_active, 1'b1);
		rc("status", OFS_CONTROL, 32'h48);
		pulse(1'b0);
		st("idle", sec_idle_active, 1'b1);
		st("osc", osc_run, 1'b1);
		pulse(1'b1);
		st("idle", sec_idle_active, 1'b0);
		wr(OFS_OSC_CTRL, 32'h0);
		st("sec", secondary_clock_active, 1'b0);
		// External pin, synchronised, then unsynchronised through sleep
		wr(OFS_COUNT_LOW, 32'h0);
		wr(OFS_COUNT_HIGH, 32'h0);
		wr(OFS_CONTROL, 32'h03);
		src_i.pulses(5);
		repeat (8) @(posedge hclk);
		wr(OFS_CONTROL, 32'h0);
		rc("ext", OFS_COUNT_LOW, 32'h5);
		wr(OFS_ENABLE, 32'h1);
		wr(OFS_COUNT_LOW, 32'hfd);
		wr(OFS_COUNT_HIGH, 32'hff);
		wr(OFS_CONTROL, 32'h07);
		pulse(1'b0);
		st("sleep", sleep_active, 1'b1);
		src_i.pulses(4);
		st("irq", overflow_irq, 1'b1);
		st("wake", sleep_active, 1'b0);
		wr(OFS_CONTROL, 32'h0);
		rc("async", OFS_COUNT_LOW, 32'h1);
		tally_and_finish();
	end
endmodule
